/* File: rtl/msq_defines.svh */
// Purpose: constants for the microsequencer next-state block
// Assumes: 8-bit addresses, labels, constants and inputs
// Notes:   header of definitions only
`ifndef MSQ_DEFINES_SVH
`define MSQ_DEFINES_SVH

`define MSQ_ADDR_W        8
`define MSQ_STACK_DEPTH   8
`define MSQ_STACK_PTR_W   4
`define MSQ_OP_W          4
`define MSQ_RESET_ADDR    8'h00
`define MSQ_RESET_COUNT   8'h00
`define MSQ_MWB_BASE      8'hC8
`define MSQ_MWB_MASK      8'hFC
`define MSQ_WORD_W        32
`define MSQ_WAYS          4

`endif

/* File: rtl/msq_pkg.sv */
// Purpose: types shared by the microsequencer files
// Assumes: msq_defines.svh sets the widths
// Notes:   opcode codes are this design's own encoding
`default_nettype none
`include "msq_defines.svh"

package msq_pkg;

  typedef enum logic [3:0] {
    OP_CONTINUE   = 4'h0,
    OP_JUMP       = 4'h1,
    OP_CALL       = 4'h2,
    OP_RETURN     = 4'h3,
    OP_LOAD_CNT   = 4'h4,
    OP_LOOP_NZ    = 4'h5,
    OP_DEC_NZ     = 4'h6,
    OP_SAVE_LOAD  = 4'h7,
    OP_POP_CNT    = 4'h8,
    OP_PUSH_CONST = 4'h9,
    OP_PUSH_IN    = 4'hA,
    OP_PUSH_MASK  = 4'hB,
    OP_POP_XOR    = 4'hC
  } msq_op_t;

  // one microword: opcode, jump label field, data field, outputs
  typedef struct packed {
    msq_op_t    op;
    logic [7:0] jump_label;
    logic [7:0] data;
    logic [11:0] user_out;
  } msq_word_t;

  typedef struct packed {
    logic       push;
    logic       pop;
    logic [7:0] value;
  } msq_stack_req_t;

endpackage
`default_nettype wire

/* File: rtl/msq_stack.sv */
// Purpose: lifo holding return labels, constants, inputs and counts
// Assumes: push and pop may come together only as pop-then-push
// Notes:   push on full drops the deepest entry; pop on empty reads zero
`timescale 1ns/1ps
`default_nettype none
`include "msq_defines.svh"

module msq_stack (
  input  wire logic                   sys_clk_i,
  input  wire logic                   resetn_i,
  input  wire msq_pkg::msq_stack_req_t req_i,
  output logic [7:0]                  top_o,
  output logic                        empty_o
);

  logic [7:0]                    mem [`MSQ_STACK_DEPTH];
  logic [`MSQ_STACK_PTR_W-1:0]   depth;

  assign top_o   = (depth == '0) ? 8'h00 : mem[0];
  assign empty_o = (depth == '0);

  // shift-register form: entry 0 is always the top, so overflow just loses the bottom
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < `MSQ_STACK_DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (req_i.push && !req_i.pop) begin
      mem[0] <= req_i.value;
      for (int i = 1; i < `MSQ_STACK_DEPTH; i++) begin
        mem[i] <= mem[i-1];
      end
    end else if (req_i.pop && !req_i.push) begin
      for (int i = 0; i < `MSQ_STACK_DEPTH - 1; i++) begin
        mem[i] <= mem[i+1];
      end
      mem[`MSQ_STACK_DEPTH-1] <= 8'h00;
    end else if (req_i.pop && req_i.push) begin
      mem[0] <= req_i.value;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      depth <= '0;
    end else if (req_i.push && !req_i.pop && depth != `MSQ_STACK_PTR_W'(`MSQ_STACK_DEPTH)) begin
      depth <= depth + 1'b1;
    end else if (req_i.pop && !req_i.push && depth != '0) begin
      depth <= depth - 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/msq_branch_sel.sv */
// Purpose: multi-way branch select among four words of one block
// Assumes: block is four aligned words at MSQ_MWB_BASE
// Notes:   select function is user-defined; here a mux of inputs picked by cond_sel_lo_i and cond_sel_hi_i
`timescale 1ns/1ps
`default_nettype none
`include "msq_defines.svh"

module msq_branch_sel (
  input  wire logic [7:0] next_addr_i,
  input  wire logic [7:0] input_pins_i,
  input  wire logic [2:0] cond_sel_lo_i,
  input  wire logic [2:0] cond_sel_hi_i,
  output logic [7:0]      word_addr_o,
  output logic            in_block_o
);

  always_comb begin
    in_block_o  = ((next_addr_i & `MSQ_MWB_MASK) == `MSQ_MWB_BASE);
    word_addr_o = next_addr_i;
    if (in_block_o) begin
      // low two bits replaced by the chosen input conditions
      word_addr_o = {next_addr_i[7:2], input_pins_i[cond_sel_hi_i], input_pins_i[cond_sel_lo_i]};
    end
  end

endmodule
`default_nettype wire

/* File: rtl/msq_seq.sv */
// Purpose: next-state control of a programmable microsequencer
// Assumes: inputs synchronous to sys_clk_i; microcode store is an array here
// Notes:   pipeline register holds the current microword
//
// Function
// - Masked input push ANDs inputs with the constant, pushes, holds the counter, goes to jump label.
// - Pop-compare pops, XORs with the constant into the counter; plain pop loads it unchanged.
// - Continue, jump and call go to the jump label holding the counter; call pushes the return label.
// - Return takes the next address from the stack top, pops it and holds the counter.
// - Counter load loads the constant; save-and-load first pushes the old counter value.
// - Decrement-if-nonzero decrements a nonzero counter; loop picks loop or zero label by counter zero.
// - Constant push pushes the constant, holds the counter, goes to the jump label.
// - Input push pushes the raw input pins, holds the counter, goes to the jump label.
// - The jump label sits in its own field; return label and constant share the data field.
// - A next address inside the multi-way block selects one of four words by the inputs.
// - Multi-way selection applies on top of every operation.
// - Addresses, labels and constants are eight bits wide.
// - Input pushes capture the eight input pins on the clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "msq_defines.svh"

module msq_seq (
  input  wire logic                 sys_clk_i,
  input  wire logic                 resetn_i,
  input  wire logic [7:0]           input_pins_i,
  input  wire logic                 prog_we_i,
  input  wire logic [7:0]           prog_addr_i,
  input  wire msq_pkg::msq_word_t   prog_word_i,
  input  wire logic [2:0]           cond_sel_lo_i,
  input  wire logic [2:0]           cond_sel_hi_i,
  output logic [11:0]               user_out_o,
  output logic [7:0]                addr_o,
  output logic [7:0]                loop_counter_o,
  output logic                      counter_zero_o
);

  // ************************************************************
  // storage and state
  // ************************************************************
  msq_pkg::msq_word_t       ucode [256];
  msq_pkg::msq_word_t       pipe;
  logic [7:0]               loop_counter;
  logic [7:0]               next_addr;
  logic [7:0]               next_counter;
  logic [7:0]               word_addr;
  logic [7:0]               stack_top;
  msq_pkg::msq_stack_req_t  stack_req;

  logic [7:0] jump_label;
  logic [7:0] data;
  logic       cnt_zero;

  assign jump_label = pipe.jump_label;
  assign data       = pipe.data;
  assign cnt_zero   = (loop_counter == 8'h00);

  msq_stack u_stack (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .req_i     (stack_req),
    .top_o     (stack_top),
    .empty_o   ()
  );

  // ************************************************************
  // next-state decode
  // ************************************************************
  always_comb begin
    next_addr       = jump_label;
    next_counter    = loop_counter;
    stack_req.push  = 1'b0;
    stack_req.pop   = 1'b0;
    stack_req.value = 8'h00;
    unique case (pipe.op)
      msq_pkg::OP_CONTINUE, msq_pkg::OP_JUMP: begin
        next_addr = jump_label;
      end
      msq_pkg::OP_CALL: begin
        stack_req.push  = 1'b1;
        stack_req.value = data;
      end
      msq_pkg::OP_RETURN: begin
        next_addr     = stack_top;
        stack_req.pop = 1'b1;
      end
      msq_pkg::OP_LOAD_CNT: begin
        next_counter = data;
      end
      msq_pkg::OP_LOOP_NZ: begin
        // loop label in the jump field, zero label in the data field
        if (cnt_zero) begin
          next_addr = data;
        end else begin
          next_counter = loop_counter - 8'h01;
        end
      end
      msq_pkg::OP_DEC_NZ: begin
        if (!cnt_zero) begin
          next_counter = loop_counter - 8'h01;
        end
      end
      msq_pkg::OP_SAVE_LOAD: begin
        stack_req.push  = 1'b1;
        stack_req.value = loop_counter;
        next_counter    = data;
      end
      msq_pkg::OP_POP_CNT: begin
        stack_req.pop = 1'b1;
        next_counter  = stack_top;
      end
      msq_pkg::OP_PUSH_CONST: begin
        stack_req.push  = 1'b1;
        stack_req.value = data;
      end
      msq_pkg::OP_PUSH_IN: begin
        // sampled on this edge, so a following return dispatches on it
        stack_req.push  = 1'b1;
        stack_req.value = input_pins_i;
      end
      msq_pkg::OP_PUSH_MASK: begin
        stack_req.push  = 1'b1;
        stack_req.value = input_pins_i & data;
      end
      msq_pkg::OP_POP_XOR: begin
        stack_req.pop = 1'b1;
        next_counter  = stack_top ^ data;
      end
      default: begin
        next_addr = jump_label;
      end
    endcase
  end

  // ************************************************************
  // multi-way branch, applied after every operation
  // ************************************************************
  msq_branch_sel u_branch (
    .next_addr_i   (next_addr),
    .input_pins_i  (input_pins_i),
    .cond_sel_lo_i (cond_sel_lo_i),
    .cond_sel_hi_i (cond_sel_hi_i),
    .word_addr_o   (word_addr),
    .in_block_o    ()
  );

  // ************************************************************
  // registers
  // ************************************************************
  // no reset on the store: it is program memory loaded through the port
  always_ff @(posedge sys_clk_i) begin
    if (prog_we_i) begin
      ucode[prog_addr_i] <= prog_word_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pipe <= '0;
    end else begin
      pipe <= ucode[word_addr];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      loop_counter <= `MSQ_RESET_COUNT;
    end else begin
      loop_counter <= next_counter;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      user_out_o     <= 12'h000;
      addr_o         <= `MSQ_RESET_ADDR;
      loop_counter_o <= `MSQ_RESET_COUNT;
      counter_zero_o <= 1'b1;
    end else begin
      user_out_o     <= ucode[word_addr].user_out;
      addr_o         <= word_addr;
      loop_counter_o <= next_counter;
      counter_zero_o <= (next_counter == 8'h00);
    end
  end

endmodule
`default_nettype wire

/* File: tb/msq_ext.sv */
// Purpose: far-side logic driving the general inputs
// Assumes: one clock shared with the sequencer
// Notes:   two flops, so pins change only just after the sampling edge
`timescale 1ns/1ps
`default_nettype none
module msq_ext (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] raw_i,
  output logic [7:0]      input_pins_o
);
  logic [7:0] sync1;
  always_ff @(posedge sys_clk_i) begin
    sync1 <= raw_i;
    input_pins_o <= sync1;
  end
endmodule
`default_nettype wire

/* File: tb/msq_chk.sv */
// Purpose: port assertions for msq_seq
// Assumes: microcode is written only while in reset
// Notes:   a shadow store mirrors the program port
`timescale 1ns/1ps
`default_nettype none
module msq_chk (
  input wire logic               sys_clk_i,
  input wire logic               resetn_i,
  input wire logic [7:0]         input_pins_i,
  input wire logic               prog_we_i,
  input wire logic [7:0]         prog_addr_i,
  input wire msq_pkg::msq_word_t prog_word_i,
  input wire logic [2:0]         cond_sel_lo_i,
  input wire logic [2:0]         cond_sel_hi_i,
  input wire logic [11:0]        user_out_o,
  input wire logic [7:0]         addr_o,
  input wire logic [7:0]         loop_counter_o,
  input wire logic               counter_zero_o
);
  msq_pkg::msq_word_t mem [256];
  msq_pkg::msq_word_t cw;
  msq_pkg::msq_op_t   op;
  logic               vld;
  logic               z;
  logic [7:0]         dat;
  logic [7:0]         nj;
  logic [7:0]         nd;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // pins and selects passed in, so the assigns below follow every change of them
  function automatic logic [7:0] mw(input logic [7:0] a, input logic [7:0] p,
                                    input logic [2:0] lo, input logic [2:0] hi);
    return ((a & 8'hFC) == 8'hC8) ? {a[7:2], p[hi], p[lo]} : a;
  endfunction
  always_ff @(posedge sys_clk_i) begin
    if (prog_we_i) begin
      mem[prog_addr_i] <= prog_word_i;
    end
  end
  // the word held during reset is not from the store
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vld <= 1'b0;
    end else begin
      vld <= 1'b1;
    end
  end
  assign cw  = mem[addr_o];
  assign op  = cw.op;
  assign dat = cw.data;
  assign z   = loop_counter_o == 8'h00;
  assign nj  = mw(cw.jump_label, input_pins_i, cond_sel_lo_i, cond_sel_hi_i);
  assign nd  = mw(cw.data, input_pins_i, cond_sel_lo_i, cond_sel_hi_i);
  // ****************
  // properties
  // ****************
  sequence s_in;
    vld && op == msq_pkg::OP_PUSH_IN ##1 op == msq_pkg::OP_RETURN;
  endsequence
  sequence s_px;
    vld && op == msq_pkg::OP_PUSH_CONST ##1 op == msq_pkg::OP_POP_XOR;
  endsequence
  property p_zero; counter_zero_o == z; endproperty
  property p_hold; vld && op inside {[4'h0:4'h3], [4'h9:4'hB]} |=> $stable(loop_counter_o);
  endproperty
  property p_load; vld && op inside {4'h4, 4'h7} |=> loop_counter_o == $past(dat); endproperty
  property p_dec; vld && !z && op inside {4'h5, 4'h6} |=>
    loop_counter_o == $past(loop_counter_o) - 8'h01; endproperty
  property p_lz; vld && z && op == msq_pkg::OP_LOOP_NZ |=> z && addr_o == $past(nd); endproperty
  property p_jump; vld && op != msq_pkg::OP_RETURN && !(z && op == msq_pkg::OP_LOOP_NZ) |=>
    addr_o == $past(nj); endproperty
  property p_ret; s_in |=> addr_o[7:2] == $past(input_pins_i[7:2], 2); endproperty
  property p_xor; s_px |=> loop_counter_o == ($past(dat, 2) ^ $past(dat)); endproperty
  property p_user; vld |-> user_out_o == cw.user_out; endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  a_hold: assert property (p_hold) else $error("counter moved");
  a_load: assert property (p_load) else $error("counter load wrong");
  a_dec: assert property (p_dec) else $error("decrement wrong");
  a_lz: assert property (p_lz) else $error("zero label wrong");
  a_jump: assert property (p_jump) else $error("next address wrong");
  a_ret: assert property (p_ret) else $error("dispatch wrong");
  a_xor: assert property (p_xor) else $error("xor compare wrong");
  a_user: assert property (p_user) else $error("user field wrong");
endmodule
bind msq_seq msq_chk i_msq_chk (.sys_clk_i, .resetn_i, .input_pins_i, .prog_we_i, .prog_addr_i,
  .prog_word_i, .cond_sel_lo_i, .cond_sel_hi_i, .user_out_o, .addr_o, .loop_counter_o,
  .counter_zero_o);
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for msq_seq
// Assumes: one program trace, run twice across a reset
// Notes:   expected trace worked out by hand
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic               sys_clk_i;
  logic               resetn_i;
  logic               prog_we_i;
  logic [7:0]         prog_addr_i;
  msq_pkg::msq_word_t prog_word_i;
  logic [7:0]         raw;
  logic [7:0]         pins;
  logic [11:0]        user_out_o;
  logic [7:0]         addr_o;
  logic [7:0]         loop_counter_o;
  logic               counter_zero_o;
  int                 n_errors;
  int                 checked;
  // {address, counter} after each edge from release
  // pins CA make the two select bits differ, so a swapped select shows up
  logic [15:0] ex [18] = '{16'h0000, 16'h0103, 16'h0205, 16'h0303, 16'h0402, 16'h0401,
    16'h0400, 16'h0500, 16'h0900, 16'h0600, 16'h0700, 16'h0803, 16'h0903, 16'hCA03,
    16'h0903, 16'h0A03, 16'h0903, 16'h0003};
  msq_ext i_msq_ext (.sys_clk_i(sys_clk_i), .raw_i(raw), .input_pins_o(pins));
  msq_seq i_msq_seq (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .input_pins_i(pins),
    .prog_we_i(prog_we_i), .prog_addr_i(prog_addr_i), .prog_word_i(prog_word_i),
    .cond_sel_lo_i(3'h0), .cond_sel_hi_i(3'h3), .user_out_o(user_out_o), .addr_o(addr_o),
    .loop_counter_o(loop_counter_o), .counter_zero_o(counter_zero_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input msq_pkg::msq_op_t o, input logic [15:0] jd);
    @(posedge sys_clk_i);
    prog_we_i <= 1'b1;
    prog_addr_i <= a;
    prog_word_i <= '{o, jd[15:8], jd[7:0], {4'h0, a}};
  endtask
  task automatic step(input int i);
    @(posedge sys_clk_i);
    #1;
    chk({4'h0, addr_o}, {4'h0, ex[i][15:8]});
    chk({4'h0, loop_counter_o}, {4'h0, ex[i][7:0]});
    chk({11'h0, counter_zero_o}, {11'h0, ex[i][7:0] == 8'h00});
    chk(user_out_o, {4'h0, ex[i][15:8]});
  endtask
  task automatic t_reset();
    chk({4'h0, addr_o}, 12'h000);
    chk({11'h0, counter_zero_o}, 12'h001);
  endtask
  task automatic t_counter();
    for (int i = 0; i < 8; i++) step(i);
  endtask
  task automatic t_stack();
    for (int i = 8; i < 12; i++) step(i);
  endtask
  task automatic t_dispatch();
    for (int i = 12; i < 18; i++) step(i);
  endtask
  task automatic final_report();
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    resetn_i = 1'b0;
    prog_we_i = 1'b0;
    prog_addr_i = 8'h00;
    prog_word_i = '0;
    raw = 8'hCA;
    n_errors = 0;
    checked = 0;
    // reset is held low for the whole program load and released only after it
    wr(8'h00, msq_pkg::OP_LOAD_CNT, 16'h0103);
    wr(8'h01, msq_pkg::OP_SAVE_LOAD, 16'h0205);
    wr(8'h02, msq_pkg::OP_POP_CNT, 16'h0300);
    wr(8'h03, msq_pkg::OP_DEC_NZ, 16'h0400);
    wr(8'h04, msq_pkg::OP_LOOP_NZ, 16'h0405);
    wr(8'h05, msq_pkg::OP_CALL, 16'h0906);
    wr(8'h06, msq_pkg::OP_PUSH_CONST, 16'h070F);
    wr(8'h07, msq_pkg::OP_POP_XOR, 16'h080C);
    wr(8'h08, msq_pkg::OP_PUSH_IN, 16'h0900);
    wr(8'h09, msq_pkg::OP_RETURN, 16'h0000);
    wr(8'h0A, msq_pkg::OP_JUMP, 16'h0900);
    wr(8'hCA, msq_pkg::OP_PUSH_MASK, 16'h090F);
    @(posedge sys_clk_i);
    prog_we_i <= 1'b0;
    repeat (2) begin
      #1;
      t_reset();
      @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      t_counter();
      t_stack();
      t_dispatch();
      @(posedge sys_clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
    end
    final_report();
  end
endmodule
`default_nettype wire
